// ===== verilog/dac_link_pkg.sv
`default_nettype none
package dac_link_pkg;
	// Serial word layout
	localparam int WORD_BITS = 24;
	localparam int DATA_BITS = 16;
	localparam int NUM_CH = 4;
	localparam int RW_POS = 23;
	localparam int SEL_HI = 21;
	localparam int SEL_LO = 19;
	localparam int CH_HI = 18;
	localparam int CH_LO = 16;
	localparam logic [4:0] LAST_BIT_IDX = 5'h17;
	localparam logic [1:0] WORDS_MAX = 2'h3;
	localparam logic [2:0] CH_ALL = 3'h4;

	// Register select codes carried in the word
	typedef enum logic [2:0] {
		REG_DAC = 3'b000,
		REG_RANGE = 3'b001,
		REG_POWER = 3'b010,
		REG_CONTROL = 3'b011
	} reg_sel_type;

	// Channel field meaning under REG_CONTROL
	localparam logic [2:0] CTL_NOP = 3'h0;
	localparam logic [2:0] CTL_CONFIG = 3'h1;
	localparam logic [2:0] CTL_CLEAR = 3'h4;
	localparam logic [2:0] CTL_LOAD = 3'h5;
	localparam int CFG_SDO_DIS = 0;
	localparam int CFG_CLR_MID = 1;

	typedef enum logic {
		LINK_IDLE = 1'b0,
		LINK_FRAME = 1'b1
	} link_state_type;

	localparam logic [15:0] DAC_RESET = 16'h0000;
	localparam logic [15:0] MID_SCALE = 16'h8000;

	// Pin positions in the synchroniser vector
	localparam int PIN_COUNT = 5;
	localparam int PIN_SCLK = 0;
	localparam int PIN_FRAME = 1;
	localparam int PIN_SERIAL_DATA_IN = 2;
	localparam int PIN_LOAD = 3;
	localparam int PIN_CLEAR = 4;
	localparam logic [4:0] PIN_INIT = 5'h1A;

	// APB register map
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SETUP = 8'h08;
	localparam logic [7:0] OFS_DAC_BASE = 8'h10;
	localparam logic [7:0] OFS_INPUT_BASE = 8'h20;
	localparam int ST_ACTIVE = 0;
	localparam int ST_RD_PEND = 1;
	localparam int ST_INVALID = 2;
	localparam int ST_SDO_ON = 3;
	localparam int ST_POWER_LO = 8;
	localparam int ST_COUNT_LO = 16;
	localparam int SETUP_RANGE_LO = 4;
endpackage
`default_nettype wire

// ===== verilog/link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface link_if;
	logic clk_rise;
	logic clk_fall;
	logic frame_low;
	logic frame_fall;
	logic frame_rise;
	logic data_in;
	logic load_low;
	logic load_fall;
	logic clear_low;
	modport source(output clk_rise, clk_fall, frame_low, frame_fall,
		frame_rise, data_in, load_low, load_fall, clear_low);
	modport sink(input clk_rise, clk_fall, frame_low, frame_fall,
		frame_rise, data_in, load_low, load_fall, clear_low);
endinterface
`default_nettype wire

// ===== verilog/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync
#(
	parameter int WIDTH = 5,
	parameter logic [WIDTH-1:0] INIT = '0
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= INIT;
			q <= INIT;
		end
		else if (ce)
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/link_edges.sv
`timescale 1ns/10ps
`default_nettype none
module link_edges
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [dac_link_pkg::PIN_COUNT-1:0] level,
	link_if.source lnk
);
	logic [dac_link_pkg::PIN_COUNT-1:0] prev_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prev_r <= dac_link_pkg::PIN_INIT;
		else if (ce)
			prev_r <= level;
	end

	always_comb
	begin
		lnk.clk_rise = level[dac_link_pkg::PIN_SCLK] &
			~prev_r[dac_link_pkg::PIN_SCLK];
		lnk.clk_fall = ~level[dac_link_pkg::PIN_SCLK] &
			prev_r[dac_link_pkg::PIN_SCLK];
		lnk.frame_low = ~level[dac_link_pkg::PIN_FRAME];
		lnk.frame_fall = ~level[dac_link_pkg::PIN_FRAME] &
			prev_r[dac_link_pkg::PIN_FRAME];
		lnk.frame_rise = level[dac_link_pkg::PIN_FRAME] &
			~prev_r[dac_link_pkg::PIN_FRAME];
		lnk.data_in = level[dac_link_pkg::PIN_SERIAL_DATA_IN];
		lnk.load_low = ~level[dac_link_pkg::PIN_LOAD];
		lnk.load_fall = ~level[dac_link_pkg::PIN_LOAD] &
			prev_r[dac_link_pkg::PIN_LOAD];
		lnk.clear_low = ~level[dac_link_pkg::PIN_CLEAR];
	end
endmodule
`default_nettype wire

// ===== verilog/quad_dac_serial_load_interface.sv
`timescale 1ns/10ps
`default_nettype none
module quad_dac_serial_load_interface
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_clock,
	input wire logic frame_select_n,
	input wire logic serial_data_in,
	input wire logic load_outputs_n,
	input wire logic clear_n,
	output logic serial_data_out,
	output logic serial_data_out_oe,
	output logic [3:0][15:0] dac_code,
	output logic [3:0] channel_powered
);
	logic [dac_link_pkg::PIN_COUNT-1:0] pin_level;
	logic [dac_link_pkg::PIN_COUNT-1:0] pin_synced;
	link_if lnk();

	dac_link_pkg::link_state_type state_r;
	logic [23:0] shift_r;
	logic [4:0] bit_cnt_r;
	logic [1:0] words_r;
	logic sdo_r;
	logic sdo_oe_r;
	logic read_pending_r;
	logic read_active_r;
	logic [5:0] read_sel_r;
	logic [3:0][15:0] input_r;
	logic [3:0][15:0] dac_r;
	logic [3:0][2:0] range_r;
	logic [3:0] power_r;
	logic [1:0] config_r;
	logic daisy_en_r;
	logic invalid_r;
	logic [7:0] frame_cnt_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	logic word_done;
	logic word_valid;
	logic write_go;
	logic w_rw;
	logic [2:0] w_sel;
	logic [2:0] w_ch;
	logic [15:0] w_data;
	logic ctl_wr;
	logic load_all;
	logic clear_now;
	logic [15:0] clear_code;
	logic [15:0] rb_value;
	logic [23:0] rb_word;
	logic apb_access;
	logic apb_setup;
	logic [7:0] addr_w;
	logic [31:0] rd_mux;
	logic rd_ok;

	function automatic logic chan_hit(input logic [2:0] ch, input int idx);
		chan_hit = (ch == dac_link_pkg::CH_ALL) || (ch == 3'(idx));
	endfunction

	always_comb
	begin
		pin_level = '0;
		pin_level[dac_link_pkg::PIN_SCLK] = serial_clock;
		pin_level[dac_link_pkg::PIN_FRAME] = frame_select_n;
		pin_level[dac_link_pkg::PIN_SERIAL_DATA_IN] = serial_data_in;
		pin_level[dac_link_pkg::PIN_LOAD] = load_outputs_n;
		pin_level[dac_link_pkg::PIN_CLEAR] = clear_n;
	end

	pin_sync #(
		.WIDTH(dac_link_pkg::PIN_COUNT),
		.INIT(dac_link_pkg::PIN_INIT)
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.ce(ce),
		.d(pin_level),
		.q(pin_synced)
	);

	link_edges u_edges (
		.clk(pclk),
		.rst_n(presetn),
		.ce(ce),
		.level(pin_synced),
		.lnk(lnk.source)
	);

	// Word fields, decoded from the completed shift register
	assign w_rw = shift_r[dac_link_pkg::RW_POS];
	assign w_sel = shift_r[dac_link_pkg::SEL_HI:dac_link_pkg::SEL_LO];
	assign w_ch = shift_r[dac_link_pkg::CH_HI:dac_link_pkg::CH_LO];
	assign w_data = shift_r[dac_link_pkg::DATA_BITS-1:0];

	// Chained words are only accepted as whole multiples of 24 when enabled
	assign word_done = lnk.frame_rise &&
		(state_r == dac_link_pkg::LINK_FRAME);
	assign word_valid = word_done && (bit_cnt_r == 5'h00) &&
		(words_r != 2'h0) && (daisy_en_r || words_r == 2'h1);
	assign write_go = word_valid && !w_rw;
	assign ctl_wr = write_go && (w_sel == dac_link_pkg::REG_CONTROL);
	assign load_all = (lnk.load_fall && !lnk.frame_low) ||
		(ctl_wr && w_ch == dac_link_pkg::CTL_LOAD);
	assign clear_now = lnk.clear_low ||
		(ctl_wr && w_ch == dac_link_pkg::CTL_CLEAR);
	assign clear_code = config_r[dac_link_pkg::CFG_CLR_MID] ?
		dac_link_pkg::MID_SCALE : dac_link_pkg::DAC_RESET;

	// Frame sequencing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= dac_link_pkg::LINK_IDLE;
		else if (ce)
		begin
			case (state_r)
				dac_link_pkg::LINK_IDLE:
					if (lnk.frame_fall)
						state_r <= dac_link_pkg::LINK_FRAME;
				dac_link_pkg::LINK_FRAME:
					if (lnk.frame_rise)
						state_r <= dac_link_pkg::LINK_IDLE;
				default:
					state_r <= dac_link_pkg::LINK_IDLE;
			endcase
		end
	end

	// Falling clock edges counted modulo 24, whole words saturating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_cnt_r <= 5'h00;
			words_r <= 2'h0;
		end
		else if (ce)
		begin
			if (state_r == dac_link_pkg::LINK_IDLE && lnk.frame_fall)
			begin
				bit_cnt_r <= 5'h00;
				words_r <= 2'h0;
			end
			else if (state_r == dac_link_pkg::LINK_FRAME && lnk.clk_fall)
			begin
				if (bit_cnt_r == dac_link_pkg::LAST_BIT_IDX)
				begin
					bit_cnt_r <= 5'h00;
					if (words_r != dac_link_pkg::WORDS_MAX)
						words_r <= words_r + 2'h1;
				end
				else
					bit_cnt_r <= bit_cnt_r + 5'h01;
			end
		end
	end

	// Readback source, picked by the select latched from the read request
	always_comb
	begin
		rb_value = 16'h0000;
		case (dac_link_pkg::reg_sel_type'(read_sel_r[5:3]))
			dac_link_pkg::REG_DAC:
				if (read_sel_r[2] == 1'b0)
					rb_value = dac_r[read_sel_r[1:0]];
			dac_link_pkg::REG_RANGE:
				if (read_sel_r[2] == 1'b0)
					rb_value = {13'h0000, range_r[read_sel_r[1:0]]};
			dac_link_pkg::REG_POWER:
				rb_value = {12'h000, power_r};
			dac_link_pkg::REG_CONTROL:
				rb_value = {14'h0000, config_r};
			default:
				rb_value = 16'h0000;
		endcase
		rb_word = {2'b10, read_sel_r, rb_value};
	end

	// Shift register and serial output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shift_r <= 24'h000000;
			sdo_r <= 1'b0;
		end
		else if (ce)
		begin
			if (state_r == dac_link_pkg::LINK_IDLE && lnk.frame_fall)
			begin
				if (read_pending_r)
				begin
					shift_r <= rb_word;
					sdo_r <= rb_word[dac_link_pkg::RW_POS];
				end
				else
					sdo_r <= shift_r[dac_link_pkg::RW_POS];
			end
			else if (state_r == dac_link_pkg::LINK_FRAME)
			begin
				if (lnk.clk_fall)
					shift_r <= {shift_r[22:0], lnk.data_in};
				if (lnk.clk_rise)
					sdo_r <= shift_r[dac_link_pkg::RW_POS];
			end
		end
	end

	// Readback request and the frame that carries its answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			read_pending_r <= 1'b0;
			read_active_r <= 1'b0;
			read_sel_r <= 6'h00;
		end
		else if (ce)
		begin
			if (state_r == dac_link_pkg::LINK_IDLE && lnk.frame_fall)
			begin
				read_active_r <= read_pending_r;
				read_pending_r <= 1'b0;
			end
			else if (word_done)
			begin
				read_active_r <= 1'b0;
				if (word_valid && w_rw)
				begin
					read_pending_r <= 1'b1;
					read_sel_r <= {w_sel, w_ch};
				end
			end
		end
	end

	// Output enable follows software, overridden during readback
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sdo_oe_r <= 1'b1;
		else if (ce)
			sdo_oe_r <= ~config_r[dac_link_pkg::CFG_SDO_DIS] |
				read_active_r;
	end

	// Setup registers written over the serial word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			power_r <= 4'h0;
			range_r <= '0;
			config_r <= 2'b00;
		end
		else if (ce && write_go)
		begin
			if (w_sel == dac_link_pkg::REG_POWER)
				power_r <= w_data[3:0];
			if (ctl_wr && w_ch == dac_link_pkg::CTL_CONFIG)
				config_r <= w_data[1:0];
			for (int i = 0; i < dac_link_pkg::NUM_CH; i++)
				if (w_sel == dac_link_pkg::REG_RANGE && chan_hit(w_ch, i))
					range_r[i] <= w_data[2:0];
		end
	end

	// Input registers take data only for powered channels
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			input_r <= '0;
		else if (ce && write_go && w_sel == dac_link_pkg::REG_DAC)
		begin
			for (int i = 0; i < dac_link_pkg::NUM_CH; i++)
				if (chan_hit(w_ch, i) && power_r[i])
					input_r[i] <= w_data;
		end
	end

	// DAC registers: clear beats any load, so a held clear pins the code
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dac_r <= '0;
		else if (ce)
		begin
			for (int i = 0; i < dac_link_pkg::NUM_CH; i++)
			begin
				if (clear_now)
					dac_r[i] <= clear_code;
				else if (load_all)
					dac_r[i] <= input_r[i];
				else if (write_go && w_sel == dac_link_pkg::REG_DAC &&
					chan_hit(w_ch, i) && power_r[i] && lnk.load_low)
					dac_r[i] <= w_data;
			end
		end
	end

	// APB slave: pready follows ce, so wait states only while ce is low, read data captured in the setup cycle
	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable && ce;
	assign addr_w = {paddr[7:2], 2'b00};

	always_comb
	begin
		rd_mux = 32'h00000000;
		rd_ok = 1'b1;
		if (addr_w == dac_link_pkg::OFS_CONFIG)
			rd_mux[0] = daisy_en_r;
		else if (addr_w == dac_link_pkg::OFS_STATUS)
		begin
			rd_mux[dac_link_pkg::ST_ACTIVE] = lnk.frame_low;
			rd_mux[dac_link_pkg::ST_RD_PEND] = read_pending_r;
			rd_mux[dac_link_pkg::ST_INVALID] = invalid_r;
			rd_mux[dac_link_pkg::ST_SDO_ON] = sdo_oe_r;
			rd_mux[dac_link_pkg::ST_POWER_LO +: 4] = power_r;
			rd_mux[dac_link_pkg::ST_COUNT_LO +: 8] = frame_cnt_r;
		end
		else if (addr_w == dac_link_pkg::OFS_SETUP)
		begin
			rd_mux[1:0] = config_r;
			rd_mux[dac_link_pkg::SETUP_RANGE_LO +: 12] = range_r;
		end
		else if (addr_w[7:4] == dac_link_pkg::OFS_DAC_BASE[7:4])
			rd_mux[15:0] = dac_r[addr_w[3:2]];
		else if (addr_w[7:4] == dac_link_pkg::OFS_INPUT_BASE[7:4])
			rd_mux[15:0] = input_r[addr_w[3:2]];
		else
			rd_ok = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end
		else if (ce && apb_setup)
		begin
			prdata_r <= pwrite ? 32'h00000000 : rd_mux;
			pslverr_r <= ~rd_ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			daisy_en_r <= 1'b0;
		else if (apb_access && pwrite && addr_w == dac_link_pkg::OFS_CONFIG)
			daisy_en_r <= pwdata[0];
	end

	// A bad frame in the same cycle as a clear keeps the flag set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			invalid_r <= 1'b0;
		else if (ce)
		begin
			if (word_done && !word_valid)
				invalid_r <= 1'b1;
			else if (apb_access && pwrite &&
				addr_w == dac_link_pkg::OFS_STATUS &&
				pwdata[dac_link_pkg::ST_INVALID])
				invalid_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			frame_cnt_r <= 8'h00;
		else if (ce && word_valid)
			frame_cnt_r <= frame_cnt_r + 8'h01;
	end

	assign prdata = prdata_r;
	assign pready = ce;
	assign pslverr = apb_access && pslverr_r;
	assign serial_data_out = sdo_r;
	assign serial_data_out_oe = sdo_oe_r;
	assign dac_code = dac_r;
	assign channel_powered = power_r;
endmodule
`default_nettype wire

// ===== tb/dac_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module dac_link_asserts
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_clock,
	input wire logic frame_select_n,
	input wire logic load_outputs_n,
	input wire logic clear_n,
	input wire logic serial_data_out,
	input wire logic [3:0][15:0] dac_code,
	input wire logic [3:0] channel_powered
);
	logic [3:0] pin_r;
	logic [3:0] upd_age_r;
	logic [3:0] sdo_age_r;
	logic [3:0] pow_age_r;
	logic frame_rise;
	logic upd_ev;
	logic sdo_ev;
	logic unmapped;
	assign frame_rise = frame_select_n && !pin_r[1];
	assign upd_ev = frame_rise || (pin_r[2] && !load_outputs_n)
		|| pin_r[3] != clear_n;
	assign sdo_ev = (serial_clock && !pin_r[0]) || frame_select_n != pin_r[1];
	assign unmapped = paddr[7:2] == 6'h03 || paddr[7:2] > 6'h0B;
	function automatic logic [3:0] age(input logic [3:0] a, input logic ev);
		return ev ? 4'h0 : (a == 4'hF ? a : a + 4'h1);
	endfunction
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			pin_r <= 4'hE;
		else
			pin_r <= {clear_n, load_outputs_n, frame_select_n, serial_clock};
	// Pins pass a synchroniser first, so causes lead effects by a few cycles
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			upd_age_r <= 4'hF;
		else
			upd_age_r <= age(upd_age_r, upd_ev);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			sdo_age_r <= 4'hF;
		else
			sdo_age_r <= age(sdo_age_r, sdo_ev);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			pow_age_r <= 4'hF;
		else
			pow_age_r <= age(pow_age_r, frame_rise);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_reset_codes: assert property ($rose(presetn) |-> dac_code == '0
		&& channel_powered == 4'h0) else $error("codes not cleared by reset");
	a_update_cause: assert property (!$stable(dac_code) |-> upd_age_r <= 4'h8)
		else $error("dac code changed without frame, load or clear");
	a_power_cause: assert property (!$stable(channel_powered)
		|-> pow_age_r <= 4'h8) else $error("power bits changed off frame end");
	a_sdo_edge: assert property (!$stable(serial_data_out)
		|-> sdo_age_r <= 4'h8) else $error("data out moved off clock rise");
	a_clear_hold: assert property ((!clear_n)[*8] |-> $stable(dac_code))
		else $error("dac code changed while clear low");
	a_framed_hold: assert property ((!frame_select_n && clear_n)[*8]
		|-> $stable(dac_code)) else $error("dac code changed inside frame");
	a_ready_ce: assert property (psel |-> pready == ce)
		else $error("ready does not follow enable");
	a_err_unmapped: assert property (psel && penable && unmapped |-> pslverr)
		else $error("no error on unmapped access");
	a_err_mapped: assert property (psel && penable && !unmapped |-> !pslverr)
		else $error("error on mapped access");
	c_long_frame: cover property ((!frame_select_n)[*8]);
	c_load_fall: cover property ($fell(load_outputs_n) && frame_select_n);
	c_clear: cover property ((!clear_n)[*8]);
endmodule
bind quad_dac_serial_load_interface dac_link_asserts i_dac_link_asserts (
	.pclk, .presetn, .ce, .psel, .penable, .paddr, .pready, .pslverr,
	.serial_clock, .frame_select_n, .load_outputs_n, .clear_n,
	.serial_data_out, .dac_code, .channel_powered);
`default_nettype wire

// ===== tb/dac_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dac_host_model
(
	output logic serial_clock,
	output logic frame_select_n,
	output logic serial_data_in,
	output logic load_outputs_n,
	output logic clear_n,
	input wire logic serial_data_out
);
	localparam time HALF = 16ns;
	logic [23:0] rx;
	// Gated clock: stands low between frames
	initial
	begin
		serial_clock = 1'b0;
		frame_select_n = 1'b1;
		serial_data_in = 1'b0;
		load_outputs_n = 1'b1;
		clear_n = 1'b1;
		rx = 24'h000000;
	end
	task automatic send(input logic [23:0] w, input int n, input logic ld_low);
		int i;
		load_outputs_n = !ld_low;
		frame_select_n = 1'b0;
		serial_data_in = w[23];
		#HALF;
		for (i = 1; i <= n; i++)
		begin
			serial_clock = 1'b1;
			#HALF;
			serial_clock = 1'b0;
			rx = {rx[22:0], serial_data_out};
			#HALF;
			// Past 24 bits the word repeats, so a chain of two gets it twice
			serial_data_in = w[23 - (i % 24)];
		end
		frame_select_n = 1'b1;
		serial_data_in = !serial_data_in;
		#(4 * HALF);
	endtask
	task automatic pulse_load();
		load_outputs_n = 1'b0;
		#(4 * HALF);
		load_outputs_n = 1'b1;
		#(4 * HALF);
	endtask
	task automatic hold_clear(input logic lvl);
		clear_n = lvl;
		#(4 * HALF);
	endtask
endmodule
`default_nettype wire

// ===== tb/quad_dac_serial_load_interface_tb.sv
`timescale 1ns/10ps
`default_nettype none
module quad_dac_serial_load_interface_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic serial_clock, frame_select_n, serial_data_in;
	logic load_outputs_n, clear_n, serial_data_out, serial_data_out_oe;
	logic [3:0][15:0] dac_code;
	logic [3:0] channel_powered;
	wire logic sdo_line;
	logic [31:0] q;
	logic err;
	int n_fail = 0;
	int check_count = 0;
	always #2 pclk = ~pclk;
	// No pull on the line: a disabled output reads as high impedance
	assign sdo_line = serial_data_out_oe ? serial_data_out : 1'bz;
	quad_dac_serial_load_interface i_quad_dac_serial_load_interface (
		.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .serial_clock, .frame_select_n,
		.serial_data_in, .load_outputs_n, .clear_n, .serial_data_out,
		.serial_data_out_oe, .dac_code, .channel_powered);
	dac_host_model i_dac_host_model (.serial_clock, .frame_select_n,
		.serial_data_in, .load_outputs_n, .clear_n,
		.serial_data_out(sdo_line));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait states are the slave's business; only the watchdog ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#100us;
		n_fail++;
		results();
	end
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		check(dac_code[1:0], 32'h0);
		check(dac_code[3:2], 32'h0);
		check({28'h0, channel_powered}, 32'h0);
		#100;
		i_dac_host_model.send(24'h001234, 24, 1'b1);
		check(dac_code[1:0], 32'h0);
		i_dac_host_model.send(24'h10000F, 24, 1'b0);
		check({28'h0, channel_powered}, 32'hF);
		i_dac_host_model.send(24'h001234, 24, 1'b1);
		check(dac_code[1:0], 32'h00001234);
		i_dac_host_model.send(24'h01ABCD, 24, 1'b0);
		check(dac_code[1:0], 32'h00001234);
		i_dac_host_model.pulse_load();
		check(dac_code[1:0], 32'hABCD1234);
		i_dac_host_model.send(24'h025555, 23, 1'b1);
		i_dac_host_model.send(24'h025555, 25, 1'b1);
		check(dac_code[3:2], 32'h0);
		i_dac_host_model.send(24'h5A3C96, 48, 1'b0);
		check({8'h00, i_dac_host_model.rx}, 32'h005A3C96);
		apb(1'b0, dac_link_pkg::OFS_STATUS, 32'h0);
		check({31'h0, q[dac_link_pkg::ST_INVALID]}, 32'h1);
		check({28'h0, q[11:8]}, 32'hF);
		apb(1'b1, dac_link_pkg::OFS_STATUS, 32'h00000004);
		apb(1'b0, dac_link_pkg::OFS_STATUS, 32'h0);
		check({31'h0, q[dac_link_pkg::ST_INVALID]}, 32'h0);
		apb(1'b1, dac_link_pkg::OFS_DAC_BASE, 32'h0000FFFF);
		apb(1'b0, dac_link_pkg::OFS_DAC_BASE, 32'h0);
		check(q, 32'h00001234);
		apb(1'b0, 8'h0C, 32'h0);
		check({err, q[30:0]}, 32'h80000000);
		apb(1'b1, dac_link_pkg::OFS_CONFIG, 32'h00000001);
		// Enable drops for a while inside the read: the access must stall
		fork
			apb(1'b0, dac_link_pkg::OFS_CONFIG, 32'h0);
			begin
				repeat (2) @(posedge pclk);
				ce <= 1'b0;
				repeat (3) @(posedge pclk);
				ce <= 1'b1;
			end
		join
		check(q, 32'h00000001);
		i_dac_host_model.send(24'h020777, 48, 1'b1);
		check(dac_code[3:2], 32'h00000777);
		check({8'h00, i_dac_host_model.rx}, 32'h00020777);
		i_dac_host_model.send(24'h800000, 24, 1'b1);
		i_dac_host_model.send(24'h180000, 24, 1'b1);
		check({8'h00, i_dac_host_model.rx}, 32'h00801234);
		check(dac_code[1:0], 32'hABCD1234);
		i_dac_host_model.send(24'h190001, 24, 1'b1);
		i_dac_host_model.send(24'h810000, 24, 1'b1);
		i_dac_host_model.send(24'h180000, 24, 1'b1);
		check({8'h00, i_dac_host_model.rx}, 32'h0081ABCD);
		check({31'h0, serial_data_out_oe}, 32'h0);
		i_dac_host_model.hold_clear(1'b0);
		check(dac_code[1:0], 32'h0);
		i_dac_host_model.send(24'h001111, 24, 1'b1);
		check(dac_code[1:0], 32'h0);
		i_dac_host_model.hold_clear(1'b1);
		check(dac_code[1:0], 32'h0);
		results();
	end
endmodule
`default_nettype wire
